//--- design/rx_sync_word_align.sv
/*
 * receive synchronisation state machine and four-symbol word alignment for one lane.
 * assumes the decoder below flags bad symbols and forces them to the error filler code,
 * and that the lane layer above takes a word whenever word_out.valid is high.
 */
`timescale 1ns/1ns
// Operation
// [R1] sync lost: go to sync check when a comma arrives
// [R2] ready: a bad symbol returns the machine to sync check
// [R3] sync check: every word passed up is the receive error word
// [R4] sync check: more than four bad symbols total leads to sync lost
// [R5] sync check: four consecutive good symbols lead to ready
// [R6] full reinit in check or ready goes to sync lost
// [R7] partial reinit in check or ready restarts sync check
// [R8] priority: full reinit, partial reinit, symbol error, good run or realignment
// [R9] ready: received words pass unchanged
// [R10] ready: word realignment goes straight to sync lost
// [R11] words hold exactly four symbols
// [R12] earliest received symbol sits in the least significant slot
// [R13] far transmitter puts commas only in the lowest slot
// [R14] word alignment happens on every comma received
// [R15] comma plus next three symbols form the first word, then groups of four
// [R16] flag realignment when a comma lands outside the lowest slot
// [R17] a word with error filler replaces itself and the previous word
// [R18] sync lost: every word passed up is the receive error word
// [R19] decoder flags bad symbols and replaces them with the error filler
// [R20] counts clear on entry to sync check; a bad symbol clears the good run
// [R21] after reset: sync lost, alignment undefined until the first comma
module rx_sync_word_align
    import rx_align_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire rx_sym_t sym_in,
    input wire logic full_reinit_command_in,
    input wire logic partial_reinit_command_in,
    output rx_word_t word_out,
    output logic sync_ok_out,
    output logic realign_out
);

    // ====================================================================
    // sync state machine
    sync_state_t state_r, state_nxt;
    logic [2:0] bad_cnt_r, bad_cnt_nxt;
    logic [2:0] good_cnt_r, good_cnt_nxt;
    logic realign_evt;

    always_comb begin
        state_nxt = state_r;
        bad_cnt_nxt = bad_cnt_r;
        good_cnt_nxt = good_cnt_r;
        case (state_r)
            SYNC_LOST: begin
                if (sym_in.valid && sym_in.comma) begin // see [R1]
                    state_nxt = SYNC_CHECK;
                    bad_cnt_nxt = 3'h0; // see [R20]
                    good_cnt_nxt = 3'h0;
                end
            end
            SYNC_CHECK: begin
                if (full_reinit_command_in) begin // see [R8] see [R6]
                    state_nxt = SYNC_LOST;
                end else if (partial_reinit_command_in) begin // see [R7]
                    bad_cnt_nxt = 3'h0; // see [R20]
                    good_cnt_nxt = 3'h0;
                end else if (sym_in.valid && sym_in.bad) begin
                    good_cnt_nxt = 3'h0; // see [R20]
                    if (bad_cnt_r == BAD_LIMIT) begin // see [R4]
                        state_nxt = SYNC_LOST;
                    end else begin
                        bad_cnt_nxt = bad_cnt_r + 3'h1;
                    end
                end else if (sym_in.valid) begin
                    if (good_cnt_r == GOOD_NEEDED - 3'h1) begin // see [R5]
                        state_nxt = SYNC_READY;
                    end else begin
                        good_cnt_nxt = good_cnt_r + 3'h1;
                    end
                end
            end
            SYNC_READY: begin
                if (full_reinit_command_in) begin // see [R8] see [R6]
                    state_nxt = SYNC_LOST;
                end else if (partial_reinit_command_in ||
                             (sym_in.valid && sym_in.bad)) begin // see [R7] see [R2]
                    state_nxt = SYNC_CHECK;
                    bad_cnt_nxt = 3'h0; // see [R20]
                    good_cnt_nxt = 3'h0;
                end else if (realign_evt) begin // see [R10]
                    state_nxt = SYNC_LOST;
                end
            end
            default: begin
                state_nxt = SYNC_LOST;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            state_r <= SYNC_LOST; // see [R21]
            bad_cnt_r <= 3'h0;
            good_cnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            bad_cnt_r <= bad_cnt_nxt;
            good_cnt_r <= good_cnt_nxt;
        end
    end

    // ====================================================================
    // word assembly
    // slots are 9-bit lanes of the word; slot 0 is least significant
    logic [SYM_W-1:0] slot_r [WORD_SYMS];
    logic [SYM_W-1:0] slot_nxt [WORD_SYMS];
    logic [1:0] pos_r, pos_nxt;
    logic aligned_r, aligned_nxt;
    logic fill_r, fill_nxt;
    logic sym_fill;
    logic word_done;

    // the comma cannot be trusted to sit at pos 0 until alignment exists
    assign realign_evt = sym_in.valid && sym_in.comma && aligned_r && (pos_r != 2'h0); // see [R16]
    assign sym_fill = sym_in.code == ERR_FILL_SYM; // see [R19]

    always_comb begin
        pos_nxt = pos_r;
        aligned_nxt = aligned_r;
        fill_nxt = fill_r;
        word_done = 1'b0;
        for (int i = 0; i < WORD_SYMS; i++) begin
            slot_nxt[i] = slot_r[i];
        end
        if (sym_in.valid) begin
            if (sym_in.comma) begin // see [R14] see [R15]
                slot_nxt[0] = sym_in.code;
                pos_nxt = 2'h1;
                aligned_nxt = 1'b1;
                fill_nxt = sym_fill;
            end else if (aligned_r) begin
                slot_nxt[pos_r] = sym_in.code; // see [R12]
                fill_nxt = (pos_r == 2'h0) ? sym_fill : (fill_r | sym_fill);
                pos_nxt = pos_r + 2'h1;
                word_done = pos_r == SLOT_MAX; // see [R11]
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pos_r <= 2'h0;
            aligned_r <= 1'b0; // see [R21]
            fill_r <= 1'b0;
            for (int i = 0; i < WORD_SYMS; i++) begin
                slot_r[i] <= '0;
            end
        end else begin
            pos_r <= pos_nxt;
            aligned_r <= aligned_nxt;
            fill_r <= fill_nxt;
            for (int i = 0; i < WORD_SYMS; i++) begin
                slot_r[i] <= slot_nxt[i];
            end
        end
    end

    // ====================================================================
    // one-word hold stage so a later filler can still spoil the previous word
    // trade-off: one word of extra latency buys the backward replacement
    logic [WORD_SYMS*SYM_W-1:0] cur_word;
    logic [WORD_SYMS*SYM_W-1:0] held_r, held_nxt;
    logic held_v_r, held_v_nxt;
    logic held_bad_r, held_bad_nxt;
    logic cur_bad;
    rx_word_t word_r, word_nxt;

    always_comb begin
        cur_word = '0;
        for (int i = 0; i < WORD_SYMS - 1; i++) begin
            cur_word[i*SYM_W +: SYM_W] = slot_r[i]; // see [R12]
        end
        cur_word[(WORD_SYMS-1)*SYM_W +: SYM_W] = sym_in.code;
    end

    always_comb begin
        cur_bad = fill_r | sym_fill | (state_r != SYNC_READY); // see [R3] see [R18] see [R9]
        held_nxt = held_r;
        held_v_nxt = held_v_r;
        held_bad_nxt = held_bad_r;
        word_nxt = '0;
        if (word_done) begin
            held_nxt = cur_word;
            held_v_nxt = 1'b1;
            held_bad_nxt = cur_bad;
            word_nxt.valid = held_v_r;
            // state at leaving counts too: a word held in ready may leave during check
            // see [R17] see [R3]
            word_nxt.data = (held_bad_r || cur_bad) ? RX_ERR_WORD : held_r;
        end
        if (state_r == SYNC_LOST) begin // see [R18]
            held_bad_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            held_r <= '0;
            held_v_r <= 1'b0;
            held_bad_r <= 1'b1;
            word_r <= '0;
            realign_out <= 1'b0;
        end else begin
            held_r <= held_nxt;
            held_v_r <= held_v_nxt;
            held_bad_r <= held_bad_nxt;
            word_r <= word_nxt;
            realign_out <= realign_evt;
        end
    end

    assign word_out = word_r;
    assign sync_ok_out = state_r == SYNC_READY;

    // ====================================================================
    // assertions
    int unsigned lost_fill_cnt;
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            lost_fill_cnt <= 0;
        end else begin
            lost_fill_cnt <= (state_r == SYNC_LOST) ? lost_fill_cnt + 1 : 0;
        end
    end

    lost_to_check_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R1]
        state_r == SYNC_LOST && sym_in.valid && sym_in.comma |=> state_r == SYNC_CHECK)
        else $error("comma did not leave sync lost");
    ready_bad_sym_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R2]
        state_r == SYNC_READY && !full_reinit_command_in && sym_in.valid && sym_in.bad
        |=> state_r == SYNC_CHECK)
        else $error("bad symbol in ready did not go to check");
    check_err_word_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R3]
        state_r == SYNC_CHECK && word_done |=> !word_out.valid || word_out.data == RX_ERR_WORD)
        else $error("word passed while checking sync");
    bad_limit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R4]
        state_r == SYNC_CHECK && bad_cnt_r == BAD_LIMIT && sym_in.valid && sym_in.bad
        && !full_reinit_command_in && !partial_reinit_command_in |=> state_r == SYNC_LOST)
        else $error("fifth bad symbol did not lose sync");
    good_run_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R5]
        $rose(state_r == SYNC_READY) |-> $past(good_cnt_r) == GOOD_NEEDED - 3'h1)
        else $error("ready entered without four good symbols");
    full_reinit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R6]
        full_reinit_command_in && state_r != SYNC_LOST |=> state_r == SYNC_LOST)
        else $error("full reinit ignored");
    partial_reinit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R7]
        partial_reinit_command_in && !full_reinit_command_in && state_r != SYNC_LOST
        |=> state_r == SYNC_CHECK && bad_cnt_r == 3'h0 && good_cnt_r == 3'h0)
        else $error("partial reinit did not restart check");
    realign_lost_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R10]
        state_r == SYNC_READY && realign_evt && !full_reinit_command_in
        && !partial_reinit_command_in && !sym_in.bad |=> state_r == SYNC_LOST)
        else $error("realignment in ready kept sync");
    lost_err_word_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R18]
        lost_fill_cnt > 0 && word_out.valid |-> word_out.data == RX_ERR_WORD)
        else $error("word passed while sync lost");
    lost_stays_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R1]
        state_r == SYNC_LOST && !(sym_in.valid && sym_in.comma) |=> state_r == SYNC_LOST)
        else $error("sync lost left without a comma");
    check_bad_count_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R4]
        state_r == SYNC_CHECK && bad_cnt_r != BAD_LIMIT && sym_in.valid && sym_in.bad
        && !full_reinit_command_in && !partial_reinit_command_in
        |=> state_r == SYNC_CHECK && bad_cnt_r == $past(bad_cnt_r) + 3'h1)
        else $error("bad symbol not counted in check");
    check_stay_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R5]
        state_r == SYNC_CHECK && good_cnt_r != GOOD_NEEDED - 3'h1
        && sym_in.valid && !sym_in.bad
        && !full_reinit_command_in && !partial_reinit_command_in |=> state_r == SYNC_CHECK)
        else $error("check left before four good symbols");
    both_reinit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R8]
        full_reinit_command_in && partial_reinit_command_in && state_r != SYNC_LOST
        |=> state_r == SYNC_LOST)
        else $error("partial reinit outranked full reinit");
    entry_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R20]
        $rose(state_r == SYNC_CHECK) |-> bad_cnt_r == 3'h0 && good_cnt_r == 3'h0)
        else $error("counts not cleared on entry to check");
    bad_clears_run_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R20]
        state_r == SYNC_CHECK && sym_in.valid && sym_in.bad && !full_reinit_command_in
        |=> good_cnt_r == 3'h0)
        else $error("bad symbol kept the good run");
    check_out_err_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R3]
        word_out.valid && $past(state_r) == SYNC_CHECK |-> word_out.data == RX_ERR_WORD)
        else $error("word left the block while checking sync");
    // no disable here: the reset itself is what is watched
    reset_lost_a: assert property (@(posedge mclk_in) // see [R21]
        !rst_b_in |=> state_r == SYNC_LOST && !aligned_r && !word_out.valid)
        else $error("reset did not clear sync and alignment");

    // ====================================================================
    // assertions on word assembly and the hold stage
    early_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R21]
        !aligned_r && sym_in.valid && !sym_in.comma |=> !aligned_r && pos_r == 2'h0)
        else $error("symbol taken before the first comma");
    comma_slot_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R15]
        sym_in.valid && sym_in.comma
        |=> aligned_r && pos_r == 2'h1 && slot_r[0] == $past(sym_in.code))
        else $error("comma did not restart the word at slot 0");
    realign_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R16]
        realign_evt |=> realign_out)
        else $error("misplaced comma not flagged");
    word_size_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R11]
        word_out.valid |-> $past(pos_r) == SLOT_MAX && $past(sym_in.valid)
        && !$past(sym_in.comma))
        else $error("word emitted without four symbols");
    slot_order_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R12]
        word_done |=> held_r[SYM_W-1:0] == $past(slot_r[0])
        && held_r[(WORD_SYMS-1)*SYM_W +: SYM_W] == $past(sym_in.code))
        else $error("word slots out of arrival order");
    filler_mark_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R17]
        word_done && (fill_r || sym_fill) |=> held_bad_r)
        else $error("word with filler not marked bad");
    filler_prev_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R17]
        word_done && held_v_r && (fill_r || sym_fill)
        |=> word_out.valid && word_out.data == RX_ERR_WORD)
        else $error("word before a filler word passed");
    ready_pass_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [R9]
        state_r == SYNC_READY && word_done && held_v_r && !held_bad_r && !fill_r && !sym_fill
        |=> word_out.valid && word_out.data == $past(held_r))
        else $error("clean word altered in ready");

    // ====================================================================
    // cover properties
    reach_ready_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_r == SYNC_CHECK ##1 state_r == SYNC_READY);
    good_word_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        word_out.valid && word_out.data != RX_ERR_WORD);
    realign_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_r == SYNC_READY && realign_evt);
    lost_by_check_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_r == SYNC_CHECK ##1 state_r == SYNC_LOST);
    filler_word_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        word_done && (fill_r || sym_fill));

endmodule

//--- common/rx_align_pkg.sv
/*
 * shared types and constants for the receive sync and word alignment block.
 * assumes decoded 9-bit symbols (k flag + 8-bit code) arrive one per clock when valid.
 */
package rx_align_pkg;

    localparam int unsigned SYM_W = 9;
    localparam int unsigned WORD_SYMS = 4;
    localparam logic [1:0] SLOT_MAX = 2'h3;
    localparam logic [2:0] BAD_LIMIT = 3'h4;
    localparam logic [2:0] GOOD_NEEDED = 3'h4;
    localparam logic [8:0] ERR_FILL_SYM = 9'h100;
    localparam logic [8:0] COMMA_SYM = 9'h1bc;

    typedef enum logic [1:0] {
        SYNC_LOST = 2'b00,
        SYNC_CHECK = 2'b01,
        SYNC_READY = 2'b10
    } sync_state_t;

    typedef struct packed {
        logic valid;
        logic comma;
        logic bad;
        logic [SYM_W-1:0] code;
    } rx_sym_t;

    typedef struct packed {
        logic valid;
        logic [WORD_SYMS*SYM_W-1:0] data;
    } rx_word_t;

    localparam logic [WORD_SYMS*SYM_W-1:0] RX_ERR_WORD = {WORD_SYMS{ERR_FILL_SYM}};

endpackage

//--- bench/sym_source.sv
/*
 * symbol decoder model feeding the sync and word alignment block.
 * assumes one symbol per clock, driven at the falling edge of mclk_in.
 */
`timescale 1ns/1ns
module sym_source
    import rx_align_pkg::*;
(
    input wire logic mclk_in,
    output rx_sym_t sym_out
);
    // ==========================================================
    // symbol drive
    initial sym_out = '0;

    // a bad symbol is flagged and forced to the filler code
    task automatic send(input logic [8:0] code, input logic bad);
        @(negedge mclk_in);
        sym_out.valid = 1'b1;
        sym_out.bad = bad;
        sym_out.comma = (code == COMMA_SYM) && !bad;
        sym_out.code = bad ? ERR_FILL_SYM : code;
        @(posedge mclk_in);
        #1;
    endtask

    // idle: code flips so a stale symbol never looks held
    task automatic idle();
        @(negedge mclk_in);
        sym_out.valid = 1'b0;
        sym_out.comma = 1'b0;
        sym_out.bad = 1'b0;
        sym_out.code = ~sym_out.code;
    endtask

    // comma leads, sent first into the lowest slot
    task automatic word(input logic [8:0] s1, s2, s3);
        send(COMMA_SYM, 1'b0);
        send(s1, 1'b0);
        send(s2, 1'b0);
        send(s3, 1'b0);
    endtask
endmodule

//--- bench/rx_sync_word_align_bench.sv
/*
 * self-checking bench for the receive sync and word alignment block.
 * assumes the one-word hold of the output and level reinit commands.
 */
`timescale 1ns/1ns
module rx_sync_word_align_bench;
    import rx_align_pkg::*;
    // ==========================================================
    // signals
    localparam logic [8:0] DSYM = 9'h03c;
    logic mclk_in;
    logic rst_b_in;
    logic full_reinit_command_in;
    logic partial_reinit_command_in;
    rx_sym_t sym;
    rx_word_t word_out;
    logic sync_ok;
    logic realign;
    int failures;
    int tests_run;
    int realigns;
    logic [35:0] words[$];

    sym_source src(.mclk_in(mclk_in), .sym_out(sym));
    rx_sync_word_align rx_sync_word_align_i(
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .sym_in(sym),
        .full_reinit_command_in(full_reinit_command_in),
        .partial_reinit_command_in(partial_reinit_command_in),
        .word_out(word_out), .sync_ok_out(sync_ok), .realign_out(realign));

    // ==========================================================
    // clock, monitors, checking
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    // pulses last one cycle, so the falling edge sees each exactly once
    always @(negedge mclk_in) begin
        if (word_out.valid === 1'b1) words.push_back(word_out.data);
        if (realign === 1'b1) realigns++;
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic goods(input int n);
        repeat (n) src.send(DSYM, 1'b0);
    endtask

    // reinit command raised together with one symbol
    task automatic cmd(input logic f, input logic p, input logic bad);
        fork
            src.send(DSYM, bad);
            begin
                @(negedge mclk_in);
                full_reinit_command_in = f;
                partial_reinit_command_in = p;
            end
        join
        src.idle();
        full_reinit_command_in = 1'b0;
        partial_reinit_command_in = 1'b0;
    endtask

    // one idle cycle, then past the falling edge, so the monitor has logged the last word
    task automatic settle();
        src.idle();
        #1;
    endtask

    task automatic acquire();
        src.word(9'h011, 9'h022, 9'h033);
        chk(sync_ok, 1'b0);
        src.send(COMMA_SYM, 1'b0);
        chk(sync_ok, 1'b1);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_pass();
        chk({word_out.valid, sync_ok, realign}, 36'h0);
        goods(3);
        settle();
        chk(36'(words.size()), 36'h0);
        acquire();
        src.send(9'h0e1, 1'b0);
        src.send(9'h0e2, 1'b0);
        src.send(9'h0e3, 1'b0);
        src.word(9'h0f1, 9'h0f2, 9'h0f3);
        src.word(9'h071, 9'h072, 9'h073);
        settle();
        chk(36'(words.size()), 36'h3);
        chk(words[0], RX_ERR_WORD);
        chk(words[1], {9'h0e3, 9'h0e2, 9'h0e1, COMMA_SYM});
        chk(words[2], {9'h0f3, 9'h0f2, 9'h0f1, COMMA_SYM});
    endtask

    task automatic t_filler();
        words.delete();
        src.send(COMMA_SYM, 1'b0);
        src.send(9'h081, 1'b0);
        src.send(9'h082, 1'b1);
        chk(sync_ok, 1'b0);
        src.send(9'h083, 1'b0);
        src.word(9'h091, 9'h092, 9'h093);
        chk(sync_ok, 1'b1);
        settle();
        chk(36'(words.size()), 36'h2);
        chk(words[0], RX_ERR_WORD);
        chk(words[1], RX_ERR_WORD);
    endtask

    task automatic t_reinit();
        cmd(1'b1, 1'b1, 1'b0);
        goods(4);
        chk(sync_ok, 1'b0);
        acquire();
        cmd(1'b0, 1'b1, 1'b1);
        chk(sync_ok, 1'b0);
        repeat (4) begin
            src.send(DSYM, 1'b1);
            goods(1);
        end
        goods(2);
        chk(sync_ok, 1'b0);
        goods(1);
        chk(sync_ok, 1'b1);
        cmd(1'b0, 1'b1, 1'b0);
        repeat (5) begin
            src.send(DSYM, 1'b1);
            goods(1);
        end
        goods(4);
        chk(sync_ok, 1'b0);
        acquire();
    endtask

    // earlier scenarios may flag realignment legally, so only the increase is judged
    task automatic t_realign();
        int base;
        base = realigns;
        goods(3);
        src.send(COMMA_SYM, 1'b0);
        src.send(DSYM, 1'b0);
        chk(sync_ok, 1'b1);
        settle();
        chk(36'(realigns - base), 36'h0);
        src.send(COMMA_SYM, 1'b0);
        chk(sync_ok, 1'b0);
        goods(4);
        chk(sync_ok, 1'b0);
        chk(36'(realigns - base), 36'h1);
        acquire();
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        rst_b_in = 1'b0;
        full_reinit_command_in = 1'b0;
        partial_reinit_command_in = 1'b0;
        failures = 0;
        tests_run = 0;
        realigns = 0;
        repeat (16) @(negedge mclk_in);
        rst_b_in = 1'b1;
        t_pass();
        t_filler();
        t_reinit();
        t_realign();
        results();
    end

    // about 110 cycles are needed; ample margin before calling it a hang
    initial begin
        repeat (3000) @(posedge mclk_in);
        failures++;
        results();
    end
endmodule
